// *** can_slot_pkg.sv ***
/*
 * Constants, types and field layout for the CAN message-slot controller.
 * Assumes a single 10 MHz clock and a protocol engine outside that reports
 * frame events as one-cycle pulses.
 */
// How it works
// - both requests 0 configures; receive alone receives data
// - transmit request alone makes a data transmit slot
// - remote transmit slot sends, then receives data
// - matching identifier first turns it into receiver
// - remote receive slot answers with data afterwards
// - response lock holds back the automatic answer
// - lowest matching receive slot stores the message
// - own frames stored only in loop-back mode
// - start of frame sets receiver state if nothing is pending or sending
// - new and invalid flags set, invalid clears later
// - enabled slot raises receive interrupt, mailbox updates
// - unread slot overwritten sets message lost flag
// - pending transmit request starts at next opportunity
// - lowest request transmits; arbitration loss clears flags
// - failed transmission after winning retries same slot
// - success sets status, mailbox, enabled interrupt, sent data except on remote sender
// - sent data clear ignored while transmit request set
// - separate receive, transmit, error and wake interrupts
package can_slot_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int SLOTS  = 16;
  localparam int SLOT_W = 4;
  localparam int CTRL_W = 8;
  localparam int WORD_W = 16;
  localparam int BUF_W  = SLOT_W + 1 + WORD_W;

  // ************************************************************
  // Slot control byte layout
  // ************************************************************
  localparam int CTRL_TRQ  = 7;  // Transmit request
  localparam int CTRL_RRQ  = 6;  // Receive request
  localparam int CTRL_REM  = 5;  // Remote frame
  localparam int CTRL_LOCK = 4;  // Response lock
  localparam int CTRL_LOST = 2;  // Write 0 clears message lost
  localparam int CTRL_SENT = 1;  // Write 0 clears sent data
  localparam int CTRL_NEW  = 0;  // Write 0 clears new data

  typedef logic [SLOTS-1:0]  slot_vec_t;
  typedef logic [SLOT_W-1:0] slot_num_t;
  typedef logic [CTRL_W-1:0] ctrl_t;
  typedef logic [WORD_W-1:0] word_t;
  typedef logic [1:0]        buf_cnt_t;

  // ************************************************************
  // Reset values and handy constants
  // ************************************************************
  localparam slot_vec_t VEC_ZERO  = 16'h0000;
  localparam slot_vec_t VEC_ONE   = 16'h0001;
  localparam slot_num_t SLOT_ZERO = 4'h0;
  localparam buf_cnt_t  BUF_EMPTY = 2'h0;
  localparam buf_cnt_t  BUF_STEP  = 2'h1;
  localparam buf_cnt_t  BUF_FULL  = 2'h2;

  typedef enum {TX_IDLE, TX_ACTIVE} tx_state_t;

endpackage : can_slot_pkg

// *** rx_hold_buffer.sv ***
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes the drain side may hold ready low for any number of cycles.
 */
`timescale 1ns/1ps
module rx_hold_buffer #(
  parameter int DW = can_slot_pkg::BUF_W
) (
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          inValid,
  output logic               inReady,
  input  wire logic [DW-1:0] inData,
  output logic               outValid,
  input  wire logic          outReady,
  output logic [DW-1:0]      outData
);
  import can_slot_pkg::*;

  logic [DW-1:0] ent_q [2];
  logic          wrPtr_q;
  logic          rdPtr_q;
  buf_cnt_t      cnt_q;
  buf_cnt_t      cnt_d;
  logic          push;
  logic          pop;

  // Handshakes and flags from the occupancy count
  assign inReady  = (cnt_q != BUF_FULL);
  assign outValid = (cnt_q != BUF_EMPTY);
  assign outData  = ent_q[rdPtr_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Occupancy after this cycle's push and pop
  always_comb begin
    case ({push, pop})
      2'h2:    cnt_d = cnt_q + BUF_STEP;
      2'h1:    cnt_d = cnt_q - BUF_STEP;
      default: cnt_d = cnt_q;
    endcase
  end

  // Storage and pointers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      cnt_q   <= BUF_EMPTY;
    end else begin
      if (push) begin
        ent_q[wrPtr_q] <= inData;
        wrPtr_q        <= ~wrPtr_q;
      end
      if (pop) rdPtr_q <= ~rdPtr_q;
      cnt_q <= cnt_d;
    end
  end

endmodule : rx_hold_buffer

// *** can_message_slot_controller.sv ***
/*
 * Sixteen-slot message controller of one CAN channel: slot roles,
 * receive storage flags, transmit selection, status and interrupts.
 * Assumes a protocol engine that pulses frame events, pushes payload
 * words of an accepted frame after its receive-done pulse, and a slot
 * memory that takes words on a valid/ready port.
 */
`timescale 1ns/1ps
module can_message_slot_controller (
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    loopBack,
  input  wire logic                    swWrite,
  input  wire can_slot_pkg::slot_num_t swSlot,
  input  wire can_slot_pkg::ctrl_t     swCtrl,
  input  wire can_slot_pkg::slot_vec_t slotInterruptEnable,
  input  wire logic                    busErrEnable,
  input  wire logic                    rxSof,
  input  wire logic                    rxDone,
  input  wire can_slot_pkg::slot_vec_t rxMatch,
  input  wire logic                    rxRemote,
  input  wire logic                    rxOwn,
  input  wire logic                    rxWordValid,
  output logic                         rxWordReady,
  input  wire can_slot_pkg::word_t     rxWord,
  input  wire logic                    rxWordLast,
  output logic                         slotWrValid,
  input  wire logic                    slotWrReady,
  output can_slot_pkg::slot_num_t      slotWrSlot,
  output can_slot_pkg::word_t          slotWrWord,
  output logic                         slotWrLast,
  input  wire logic                    txBusFree,
  input  wire logic                    txArbLost,
  input  wire logic                    txFail,
  input  wire logic                    txDone,
  output logic                         txStart,
  output can_slot_pkg::slot_num_t      txSlotNum,
  input  wire logic                    errPassiveEvt,
  input  wire logic                    busOffEvt,
  input  wire logic                    busErrEvt,
  input  wire logic                    wakeEvt,
  output can_slot_pkg::slot_vec_t      newDataFlag,
  output can_slot_pkg::slot_vec_t      invalidDataFlag,
  output can_slot_pkg::slot_vec_t      messageLostFlag,
  output can_slot_pkg::slot_vec_t      sentDataFlag,
  output can_slot_pkg::slot_vec_t      transmittingActive,
  output can_slot_pkg::slot_vec_t      remoteActive,
  output logic                         receiverState,
  output logic                         transmitterState,
  output can_slot_pkg::slot_num_t      mailboxSlotNumber,
  output logic                         receptionSuccess,
  output logic                         transmissionSuccess,
  output logic                         rxIrq,
  output logic                         txIrq,
  output logic                         errIrq,
  output logic                         wakeIrq
);
  import can_slot_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  slot_vec_t trq_q, rrq_q, rem_q, lock_q;
  slot_vec_t new_data_flag_q, invalid_q, lost_q, sent_q, remAct_q, txAct_q;
  slot_num_t rxSlot_q, txSlot_q, mailbox_q;
  tx_state_t txState_q, txState_d;
  logic      retry_q, rxStore_q, rxState_q, trState_q;
  logic      reception_success_q, trnSucc_q, txStart_q;
  logic      rxIrq_q, txIrq_q, errIrq_q, wakeIrq_q;

  slot_vec_t swSel, dataRxSlot, remRxSlot, txElig, rxCand, rxHitOH;
  slot_vec_t txOH, txOkOH, txOkRemote, drainOH;
  slot_vec_t clrNew, clrLost, clrSent, armRemote, dropRemote;
  slot_num_t rxHitNum, txPick, launchNum;
  logic      rxAccept, rxHit, txActive, txPending, retryOk, txLaunch;
  logic      cfgRemote, bufInValid, drainLast;
  logic [BUF_W-1:0] bufIn, bufOut;

  function automatic slot_num_t lowestSlot(input slot_vec_t v);
    slot_num_t n;
    n = SLOT_ZERO;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (v[i]) n = slot_num_t'(i);
    end
    return n;
  endfunction : lowestSlot

  // ************************************************************
  // Slot roles
  // ************************************************************
  // data receive slot; remote sender still open to data
  assign dataRxSlot = (~trq_q & rrq_q & ~rem_q & ~lock_q)
                    | (trq_q & ~rrq_q & rem_q);
  // remote receive slot waits while remote-active is set
  assign remRxSlot  = ~trq_q & rrq_q & rem_q & remAct_q;
  // data sender, remote sender, unlocked remote answer
  assign txElig = ~sent_q & ((trq_q & ~rrq_q & ~rem_q & ~lock_q)
                | (trq_q & ~rrq_q & rem_q & remAct_q)
                | (~trq_q & rrq_q & rem_q & ~remAct_q & ~lock_q));
  assign cfgRemote = swCtrl[CTRL_REM] & (swCtrl[CTRL_TRQ] ^ swCtrl[CTRL_RRQ]);
  assign swSel     = swWrite ? (VEC_ONE << swSlot) : VEC_ZERO;
  assign armRemote  = swSel & {SLOTS{cfgRemote}} & ~trq_q & ~rrq_q;
  assign dropRemote = swSel & {SLOTS{~cfgRemote}};

  // ************************************************************
  // Reception
  // ************************************************************
  // own frames are only taken back in loop-back mode
  assign rxAccept = rxDone & (~rxOwn | loopBack);
  assign rxCand   = rxMatch & (rxRemote ? remRxSlot : dataRxSlot);
  assign rxHit    = rxAccept & (|rxCand);
  assign rxHitNum = lowestSlot(rxCand);
  assign rxHitOH  = rxHit ? (VEC_ONE << rxHitNum) : VEC_ZERO;

  // Software clears; hardware sets win in the same cycle
  assign clrNew  = swSel & {SLOTS{~swCtrl[CTRL_NEW]}};
  assign clrLost = swSel & {SLOTS{~swCtrl[CTRL_LOST]}};
  // sent data stays locked while transmit request is set
  assign clrSent = swSel & {SLOTS{~swCtrl[CTRL_SENT]}} & ~trq_q;

  // Payload path through the hold buffer, tagged with its slot
  assign bufInValid = rxWordValid & rxStore_q;
  assign bufIn      = {rxSlot_q, rxWordLast, rxWord};
  assign slotWrSlot = bufOut[BUF_W-1 -: SLOT_W];
  assign slotWrLast = bufOut[WORD_W];
  assign slotWrWord = bufOut[WORD_W-1:0];
  assign drainLast  = slotWrValid & slotWrReady & slotWrLast;
  assign drainOH    = drainLast ? (VEC_ONE << slotWrSlot) : VEC_ZERO;

  rx_hold_buffer #(.DW(BUF_W)) rx_hold_buffer_inst (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .inValid  (bufInValid),
    .inReady  (rxWordReady),
    .inData   (bufIn),
    .outValid (slotWrValid),
    .outReady (slotWrReady),
    .outData  (bufOut)
  );

  // ************************************************************
  // Transmission
  // ************************************************************
  assign txActive  = (txState_q == TX_ACTIVE);
  assign txPending = |txElig;
  assign txPick    = lowestSlot(txElig);
  assign retryOk   = retry_q & txElig[txSlot_q];
  // a failed slot is retried before any other
  assign launchNum = retryOk ? txSlot_q : txPick;
  // start as soon as the bus is free and nothing is received
  assign txLaunch  = ~txActive & txBusFree & txPending & ~rxState_q;
  assign txOH       = VEC_ONE << txSlot_q;
  assign txOkOH     = (txActive & txDone) ? txOH : VEC_ZERO;
  assign txOkRemote = txOkOH & trq_q & ~rrq_q & rem_q;

  // Transmit sequencer
  always_comb begin
    txState_d = txState_q;
    case (txState_q)
      TX_IDLE:   if (txLaunch) txState_d = TX_ACTIVE;
      TX_ACTIVE: if (txArbLost | txFail | txDone) txState_d = TX_IDLE;
      default:   txState_d = TX_IDLE;
    endcase
  end

  // ************************************************************
  // Slot control registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      trq_q  <= VEC_ZERO;
      rrq_q  <= VEC_ZERO;
      rem_q  <= VEC_ZERO;
      lock_q <= VEC_ZERO;
    end else begin
      trq_q  <= (trq_q & ~swSel) | (swSel & {SLOTS{swCtrl[CTRL_TRQ]}});
      rrq_q  <= (rrq_q & ~swSel) | (swSel & {SLOTS{swCtrl[CTRL_RRQ]}});
      rem_q  <= (rem_q & ~swSel) | (swSel & {SLOTS{swCtrl[CTRL_REM]}});
      // clearing the lock releases the answer
      lock_q <= (lock_q & ~swSel) | (swSel & {SLOTS{swCtrl[CTRL_LOCK]}});
    end
  end

  // Per-slot status flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      new_data_flag_q <= VEC_ZERO;
      invalid_q <= VEC_ZERO;
      lost_q    <= VEC_ZERO;
      sent_q    <= VEC_ZERO;
      remAct_q  <= VEC_ZERO;
    end else begin
      // new and invalid set together on a stored frame
      new_data_flag_q <= (new_data_flag_q & ~clrNew) | rxHitOH;
      invalid_q <= (invalid_q & ~drainOH) | rxHitOH;
      // overwrite of unread data marks the loss
      lost_q    <= (lost_q & ~clrLost) | (rxHitOH & new_data_flag_q);
      sent_q    <= (sent_q & ~clrSent) | (txOkOH & ~txOkRemote);
      // remote role ends on send or reception
      remAct_q  <= (remAct_q & ~dropRemote & ~rxHitOH & ~txOkOH)
                 | armRemote;
    end
  end

  // ************************************************************
  // Transmit and receive tracking
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      txState_q <= TX_IDLE;
      txAct_q   <= VEC_ZERO;
      txSlot_q  <= SLOT_ZERO;
      retry_q   <= 1'b0;
      trState_q <= 1'b0;
      txStart_q <= 1'b0;
    end else begin
      txState_q <= txState_d;
      txStart_q <= txLaunch;
      if (txLaunch) begin
        txSlot_q  <= launchNum;
        txAct_q   <= VEC_ONE << launchNum;
        trState_q <= 1'b1;
      end else if (txActive & (txArbLost | txFail | txDone)) begin
        // lost arbitration returns both flags to idle
        txAct_q   <= VEC_ZERO;
        trState_q <= 1'b0;
        // only a failure after winning keeps the retry
        retry_q   <= txFail & ~txArbLost & ~txDone;
      end
    end
  end

  // Receiver state and storing target
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxState_q <= 1'b0;
      rxStore_q <= 1'b0;
      rxSlot_q  <= SLOT_ZERO;
    end else begin
      // start of frame with nothing pending to send
      if (rxSof & ~txPending & ~txActive) rxState_q <= 1'b1;
      else if (rxDone) rxState_q <= 1'b0;
      if (rxHit) begin
        rxSlot_q  <= rxHitNum;
        rxStore_q <= 1'b1;
      end else if (bufInValid & rxWordReady & rxWordLast) begin
        rxStore_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Channel status and interrupts
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mailbox_q <= SLOT_ZERO;
      reception_success_q <= 1'b0;
      trnSucc_q <= 1'b0;
      rxIrq_q   <= 1'b0;
      txIrq_q   <= 1'b0;
      errIrq_q  <= 1'b0;
      wakeIrq_q <= 1'b0;
    end else begin
      // mailbox names the slot of the latest success
      if (rxHit) mailbox_q <= rxHitNum;
      else if (|txOkOH) mailbox_q <= txSlot_q;
      if (rxHit) reception_success_q <= 1'b1;
      else if (rxSof) reception_success_q <= 1'b0;
      if (|txOkOH) trnSucc_q <= 1'b1;
      else if (txLaunch) trnSucc_q <= 1'b0;
      // separate receive, transmit, error and wake requests
      rxIrq_q   <= |(rxHitOH & slotInterruptEnable);
      txIrq_q   <= |(txOkOH & slotInterruptEnable);
      errIrq_q  <= errPassiveEvt | busOffEvt | (busErrEvt & busErrEnable);
      wakeIrq_q <= wakeEvt;
    end
  end

  // Outputs from flip-flops
  assign newDataFlag         = new_data_flag_q;
  assign invalidDataFlag     = invalid_q;
  assign messageLostFlag     = lost_q;
  assign sentDataFlag        = sent_q;
  assign transmittingActive  = txAct_q;
  assign remoteActive        = remAct_q;
  assign receiverState       = rxState_q;
  assign transmitterState    = trState_q;
  assign mailboxSlotNumber   = mailbox_q;
  assign receptionSuccess    = reception_success_q;
  assign transmissionSuccess = trnSucc_q;
  assign txStart             = txStart_q;
  assign txSlotNum           = txSlot_q;
  assign rxIrq               = rxIrq_q;
  assign txIrq               = txIrq_q;
  assign errIrq              = errIrq_q;
  assign wakeIrq             = wakeIrq_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_remote_cfg_act: assert property (
    swWrite & cfgRemote & ~trq_q[swSlot] & ~rrq_q[swSlot] |=>
      remoteActive[$past(swSlot)])
    else $error("remote config did not set remote-active");
  a_rx_lowest_slot: assert property (
    rxHit |-> ((rxCand & (rxHitOH - VEC_ONE)) == VEC_ZERO))
    else $error("frame stored past a lower candidate");
  a_own_frame_drop: assert property (
    rxDone & rxOwn & ~loopBack & ~swWrite |=> $stable(newDataFlag))
    else $error("own frame stored outside loop-back");
  a_rx_flags_set: assert property (
    rxHit |=> ((newDataFlag & invalidDataFlag & $past(rxHitOH))
               == $past(rxHitOH)))
    else $error("new or invalid flag missing after store");
  a_rx_irq_mailbox_slot_number: assert property (
    rxHit & (|(rxHitOH & slotInterruptEnable)) |=>
      rxIrq && receptionSuccess && mailboxSlotNumber == $past(rxHitNum))
    else $error("receive interrupt or mailbox wrong");
  a_lost_overwrite: assert property (
    rxHit & (|(rxHitOH & newDataFlag)) |=>
      |(messageLostFlag & $past(rxHitOH)))
    else $error("overwrite did not set message lost");
  a_rx_state_sof: assert property (
    rxSof & ~txPending & ~txActive & ~rxDone |=> receiverState)
    else $error("receiver state not set on start of frame");
  a_tx_lowest_pick: assert property (
    txLaunch & ~retryOk |=> transmitterState &&
      transmittingActive == (VEC_ONE << $past(txPick)))
    else $error("transmit did not start on lowest slot");
  a_arb_lost_idle: assert property (
    txActive & txArbLost |=> !transmitterState &&
      transmittingActive == VEC_ZERO)
    else $error("arbitration loss left flags set");
  a_retry_same_slot: assert property (
    txLaunch & retryOk |=> txSlotNum == $past(txSlotNum))
    else $error("retry moved to another slot");
  a_lock_blocks_tx: assert property (
    txLaunch |-> !(lock_q[launchNum] && !trq_q[launchNum]))
    else $error("locked remote answer started");
  a_tx_success: assert property (
    txActive & txDone & ~rxHit & ~txOkRemote[txSlot_q] |=>
      transmissionSuccess && sentDataFlag[$past(txSlot_q)] &&
      mailboxSlotNumber == $past(txSlot_q))
    else $error("transmit success status wrong");
  a_sent_locked: assert property (
    swWrite & trq_q[swSlot] & sent_q[swSlot] |=>
      sentDataFlag[$past(swSlot)])
    else $error("sent data cleared under transmit request");

  c_rx_store: cover property (rxHit ##[1:20] drainLast);
  c_tx_success: cover property (txLaunch ##[1:200] (txActive & txDone));
  c_msg_lost: cover property (rxHit & (|(rxHitOH & newDataFlag)));
  c_tx_retry: cover property ((txActive & txFail) ##[1:50] txLaunch);

endmodule : can_message_slot_controller

// *** slot_memory_model.sv ***
/*
 * Slot memory model taking payload words from the controller.
 * Assumes the bench drives stall just after a rising edge.
 */
`timescale 1ns/1ps
module slot_memory_model (
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    stall,
  input  wire logic                    slotWrValid,
  output logic                         slotWrReady,
  input  wire can_slot_pkg::slot_num_t slotWrSlot,
  input  wire can_slot_pkg::word_t     slotWrWord,
  input  wire logic                    slotWrLast,
  output logic [7:0]                   wordCount,
  output can_slot_pkg::slot_num_t      lastSlot,
  output can_slot_pkg::word_t          lastWord
);
  import can_slot_pkg::*;
  // Busy memory holds ready low
  assign slotWrReady = !stall;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wordCount <= 8'h00;
      lastSlot  <= SLOT_ZERO;
      lastWord  <= 16'h0000;
    end else if (slotWrValid && slotWrReady) begin
      wordCount <= wordCount + 8'h01;
      lastSlot  <= slotWrSlot;
      if (slotWrLast) lastWord <= slotWrWord;
    end
  end
endmodule : slot_memory_model

// *** test_can_message_slot_controller.sv ***
/*
 * Self-checking bench of the message-slot controller.
 * Assumes the slot memory model beside it and one 10 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  nMismatch++; $display("ERROR t=%0t got %h exp %h", $time, a, b); \
  end end
module test_can_message_slot_controller;
  import can_slot_pkg::*;
  logic ref_clk = 0, sys_rst = 1, loopBack = 0, swWrite = 0;
  logic busErrEnable = 0, rxSof = 0, rxDone = 0, rxRemote = 0;
  logic rxOwn = 0, rxWordValid = 0, rxWordLast = 0, txBusFree = 0;
  logic txArbLost = 0, txFail = 0, txDone = 0, errPassiveEvt = 0;
  logic busOffEvt = 0, busErrEvt = 0, wakeEvt = 0, stall = 1, seen;
  slot_num_t swSlot = 4'h0;
  ctrl_t     swCtrl = 8'h00;
  slot_vec_t slotInterruptEnable = 16'h000c, rxMatch = 16'h0000;
  word_t     rxWord = 16'h0000;
  logic rxWordReady, slotWrValid, slotWrReady, slotWrLast, txStart;
  logic receiverState, transmitterState, receptionSuccess, rxIrq;
  logic transmissionSuccess, txIrq, errIrq, wakeIrq;
  slot_num_t slotWrSlot, txSlotNum, mailboxSlotNumber, lastSlot;
  word_t     slotWrWord, lastWord;
  slot_vec_t newDataFlag, invalidDataFlag, messageLostFlag;
  slot_vec_t sentDataFlag, transmittingActive, remoteActive;
  logic [7:0] wordCount;
  int nMismatch = 0;
  int comparisons = 0;
  can_message_slot_controller can_message_slot_controller_inst (.*);
  slot_memory_model slot_memory_model_inst (.*);
  // Clock of 100 ns period
  always #50 ref_clk = ~ref_clk;
  // Control byte write
  task automatic wr(input slot_num_t s, input ctrl_t c);
    @(posedge ref_clk);
    swWrite <= 1'b1;
    swSlot  <= s;
    swCtrl  <= c;
    @(posedge ref_clk);
    swWrite <= 1'b0;
    #1;
  endtask : wr
  // Received frame report
  task automatic rxFrame(input slot_vec_t m, input logic rem, own, lb);
    @(posedge ref_clk);
    rxDone   <= 1'b1;
    rxMatch  <= m;
    rxRemote <= rem;
    rxOwn    <= own;
    loopBack <= lb;
    @(posedge ref_clk);
    rxDone <= 1'b0;
    #1;
  endtask : rxFrame
  // Event pulses, bus-error enable level on top
  task automatic evt(input logic [8:0] v);
    @(posedge ref_clk);
    {busErrEnable, rxSof, txArbLost, txFail, txDone, errPassiveEvt,
     busOffEvt, busErrEvt, wakeEvt} <= v;
    @(posedge ref_clk);
    {rxSof, txArbLost, txFail, txDone, errPassiveEvt, busOffEvt,
     busErrEvt, wakeEvt} <= 8'h00;
    #1;
  endtask : evt
  // Frees the bus and waits a bounded time for a launch
  task automatic waitStart;
    seen = 1'b0;
    for (int i = 0; i < 12 && !seen; i++) begin
      @(posedge ref_clk);
      txBusFree <= 1'b1;
      #1;
      seen = (txStart === 1'b1);
    end
  endtask : waitStart
  // Payload words, each held until ready is sampled high
  task automatic push(input int n, input word_t w);
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rxWordValid <= 1'b1;
      rxWord      <= w + word_t'(i);
      rxWordLast  <= (i == n - 1);
      do @(posedge ref_clk); while (rxWordReady !== 1'b1);
    end
    rxWordValid <= 1'b0;
    #1;
  endtask : push
  // Verdict and end of run
  task automatic summarize;
    if (nMismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  // Watchdog against a hang
  initial begin
    #200000;
    nMismatch++;
    summarize();
  end
  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK({newDataFlag, rxWordReady}, {VEC_ZERO, 1'b1})
    wr(4'h5, 8'h00);
    wr(4'h5, 8'h40);
    wr(4'h2, 8'h00);
    wr(4'h2, 8'h40);
    evt(9'h080);
    `CHK(receiverState, 1'b1)
    rxFrame(16'h0024, 1'b0, 1'b0, 1'b0);
    `CHK({newDataFlag, invalidDataFlag}, 32'h0004_0004)
    `CHK({mailboxSlotNumber, receptionSuccess, rxIrq}, 6'h0b)
    push(2, 16'h1230);
    `CHK({rxWordReady, invalidDataFlag}, 17'h0004)
    @(posedge ref_clk);
    stall <= 1'b0;
    for (int i = 0; i < 9 && wordCount !== 8'h02; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    `CHK({invalidDataFlag, lastSlot, lastWord}, 36'h000021231)
    rxFrame(16'h0004, 1'b0, 1'b0, 1'b0);
    `CHK({messageLostFlag, rxIrq}, 17'h00009)
    push(1, 16'h0040);
    wr(4'h2, 8'h40);
    `CHK({newDataFlag, messageLostFlag}, 32'h0)
    rxFrame(16'h0080, 1'b0, 1'b0, 1'b0);
    `CHK(newDataFlag, VEC_ZERO)
    rxFrame(16'h0020, 1'b0, 1'b1, 1'b0);
    `CHK(newDataFlag, VEC_ZERO)
    rxFrame(16'h0020, 1'b0, 1'b1, 1'b1);
    `CHK({newDataFlag, rxIrq}, 17'h00040)
    push(1, 16'h0050);
    wr(4'h3, 8'h00);
    wr(4'h3, 8'h80);
    wr(4'h7, 8'h00);
    wr(4'h7, 8'h80);
    waitStart();
    `CHK({seen, txSlotNum, transmitterState}, 6'h27)
    `CHK(transmittingActive, 16'h0008)
    evt(9'h040);
    `CHK({transmittingActive, transmitterState}, 17'h0)
    waitStart();
    `CHK({seen, txSlotNum}, 5'h13)
    evt(9'h020);
    waitStart();
    `CHK({seen, txSlotNum}, 5'h13)
    evt(9'h010);
    `CHK({sentDataFlag, transmissionSuccess, txIrq}, 18'h00023)
    `CHK(mailboxSlotNumber, 4'h3)
    waitStart();
    `CHK({seen, txSlotNum}, 5'h17)
    evt(9'h010);
    `CHK({sentDataFlag, txIrq}, 17'h00110)
    wr(4'h3, 8'h80);
    `CHK(sentDataFlag[3], 1'b1)
    wr(4'h3, 8'h00);
    wr(4'h3, 8'h00);
    `CHK(sentDataFlag, 16'h0080)
    evt(9'h080);
    wr(4'h1, 8'h00);
    wr(4'h1, 8'ha0);
    rxFrame(16'h0002, 1'b0, 1'b0, 1'b0);
    `CHK({remoteActive, newDataFlag}, 32'h0000_0022)
    wr(4'h4, 8'h00);
    wr(4'h4, 8'ha0);
    `CHK(remoteActive, 16'h0010)
    waitStart();
    `CHK({seen, txSlotNum}, 5'h14)
    evt(9'h010);
    `CHK(remoteActive, VEC_ZERO)
    wr(4'h6, 8'h00);
    wr(4'h6, 8'h70);
    `CHK(remoteActive, 16'h0040)
    rxFrame(16'h0040, 1'b1, 1'b0, 1'b0);
    `CHK(remoteActive, VEC_ZERO)
    waitStart();
    `CHK(seen, 1'b0)
    wr(4'h6, 8'h60);
    waitStart();
    `CHK({seen, txSlotNum}, 5'h16)
    evt(9'h002);
    `CHK({errIrq, wakeIrq}, 2'b00)
    evt(9'h10e);
    `CHK({errIrq, wakeIrq}, 2'b10)
    evt(9'h001);
    `CHK({errIrq, wakeIrq}, 2'b01)
    summarize();
  end
endmodule : test_can_message_slot_controller
